/* File: rtl/adc_port_pkg.sv */
package adc_port_pkg;
	// Clock and timing
	localparam int CLOCK_HZ = 10_000_000;
	localparam int CLOCK_MHZ = CLOCK_HZ / 1_000_000;
	localparam int CONV_TIME_NS = 1000;
	localparam int CONV_CYCLES = (CONV_TIME_NS * CLOCK_MHZ + 999) / 1000;
	localparam int START_LOW_MIN_NS = 40;
	localparam int BUS_QUIET_MIN_NS = 125;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CONV_CYCLES - 1);

	// Data widths and buffer
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam logic [DATA_W-1:0] LATCH_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] BUS_IDLE = 16'h0000;
	localparam logic [BYTE_W-1:0] FILL_ONES = 8'hFF;

	// Control pin positions in the synchroniser vector
	localparam int PIN_CS = 0;
	localparam int PIN_RD = 1;
	localparam int PIN_CONV = 2;
	localparam int PIN_BYTE = 3;
	localparam int PIN_COUNT = 4;
	localparam logic [PIN_COUNT-1:0] PIN_RESET = 4'h7;

	typedef enum logic [0:0]
	{
		ST_ACQUIRE = 1'b0,
		ST_CONVERT = 1'b1
	} conv_state_t;
endpackage

/* File: rtl/code_fifo.sv */
`timescale 1ns/1ps
module code_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] DEPTH_C = (PTR_W+1)'(DEPTH);
	localparam logic [PTR_W:0] ONE_C = (PTR_W+1)'(1);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [PTR_W:0] count_ff;
	logic [PTR_W:0] nxt_count;
	logic ready_ff;
	logic push;
	logic pop;

	assign push = in_valid && ready_ff;
	assign pop = out_valid && out_ready;
	assign in_ready = ready_ff;
	assign out_valid = (count_ff != '0);
	assign out_data = mem[rd_ptr_ff];

	always_comb
	begin
		nxt_count = count_ff;
		if (push && !pop)
			nxt_count = count_ff + ONE_C;
		else if (pop && !push)
			nxt_count = count_ff - ONE_C;
	end

	// Storage
	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_ptr_ff] <= in_data;
	end

	// Pointers, fill level and registered ready
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			ready_ff <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + PTR_ONE;
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + PTR_ONE;
			count_ff <= nxt_count;
			ready_ff <= (nxt_count < DEPTH_C);
		end
	end
endmodule // code_fifo

/* File: rtl/adc_parallel_readout_reset.sv */
`timescale 1ns/1ps
module adc_parallel_readout_reset (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic convert_start_n,
	input wire logic byte_select,
	input wire logic [15:0] code_data,
	input wire logic code_valid,
	output logic code_ready,
	output logic [15:0] result_bus_pins,
	output logic result_bus_oe,
	output logic busy,
	output logic sampling,
	output logic self_reset
);
	logic [adc_port_pkg::PIN_COUNT-1:0] pins_raw;
	logic [adc_port_pkg::PIN_COUNT-1:0] sync1_ff;
	logic [adc_port_pkg::PIN_COUNT-1:0] sync2_ff;
	logic [adc_port_pkg::PIN_COUNT-1:0] sync3_ff;
	logic [adc_port_pkg::PIN_COUNT-1:0] stable_ff;
	logic [adc_port_pkg::PIN_COUNT-1:0] prev_ff;
	logic cs_low;
	logic rd_low;
	logic byte_high;
	logic cs_fall;
	logic conv_fall;
	adc_port_pkg::conv_state_t state_ff;
	adc_port_pkg::conv_state_t nxt_state;
	logic [adc_port_pkg::CNT_W-1:0] count_ff;
	logic [15:0] latch_ff;
	logic [15:0] bus_ff;
	logic oe_ff;
	logic busy_ff;
	logic sampling_ff;
	logic self_reset_ff;
	logic [15:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	logic start_conv;
	logic abort_conv;
	logic end_conv;
	logic [adc_port_pkg::CNT_W-1:0] conv_age_ff;

	assign pins_raw[adc_port_pkg::PIN_CS] = chip_select_n;
	assign pins_raw[adc_port_pkg::PIN_RD] = read_n;
	assign pins_raw[adc_port_pkg::PIN_CONV] = convert_start_n;
	assign pins_raw[adc_port_pkg::PIN_BYTE] = byte_select;

	// Three-stage synchronisers with agreement filter
	genvar gi;
	generate
		for (gi = 0; gi < adc_port_pkg::PIN_COUNT; gi++)
		begin : g_sync
			always_ff @(posedge clock)
			begin
				if (!reset_n)
				begin
					sync1_ff[gi] <= adc_port_pkg::PIN_RESET[gi];
					sync2_ff[gi] <= adc_port_pkg::PIN_RESET[gi];
					sync3_ff[gi] <= adc_port_pkg::PIN_RESET[gi];
					stable_ff[gi] <= adc_port_pkg::PIN_RESET[gi];
					prev_ff[gi] <= adc_port_pkg::PIN_RESET[gi];
				end
				else
				begin
					sync1_ff[gi] <= pins_raw[gi];
					sync2_ff[gi] <= sync1_ff[gi];
					sync3_ff[gi] <= sync2_ff[gi];
					if (sync2_ff[gi] == sync3_ff[gi])
						stable_ff[gi] <= sync3_ff[gi];
					prev_ff[gi] <= stable_ff[gi];
				end
			end
		end
	endgenerate

	assign cs_low = !stable_ff[adc_port_pkg::PIN_CS];
	assign rd_low = !stable_ff[adc_port_pkg::PIN_RD];
	assign byte_high = stable_ff[adc_port_pkg::PIN_BYTE];
	assign cs_fall = prev_ff[adc_port_pkg::PIN_CS] && !stable_ff[adc_port_pkg::PIN_CS];
	assign conv_fall = prev_ff[adc_port_pkg::PIN_CONV] && !stable_ff[adc_port_pkg::PIN_CONV];

	// Code buffer between quantiser and output latch
	code_fifo #(
		.WIDTH(adc_port_pkg::DATA_W),
		.DEPTH(adc_port_pkg::FIFO_DEPTH)
	) u_code_fifo (
		.clock(clock),
		.reset_n(reset_n),
		.in_data(code_data),
		.in_valid(code_valid),
		.in_ready(code_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	// Conversion events
	assign start_conv = (state_ff == adc_port_pkg::ST_ACQUIRE) && conv_fall && cs_low;
	assign abort_conv = (state_ff == adc_port_pkg::ST_CONVERT)
		&& ((conv_fall && cs_low) || cs_fall);
	assign end_conv = (state_ff == adc_port_pkg::ST_CONVERT) && !abort_conv
		&& (count_ff == adc_port_pkg::CNT_RESET) && fifo_valid;
	assign fifo_pop = end_conv;

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			adc_port_pkg::ST_ACQUIRE:
			begin
				if (start_conv)
					nxt_state = adc_port_pkg::ST_CONVERT;
			end
			adc_port_pkg::ST_CONVERT:
			begin
				if (abort_conv || end_conv)
					nxt_state = adc_port_pkg::ST_ACQUIRE;
			end
		endcase
	end

	// Conversion state
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			state_ff <= adc_port_pkg::ST_ACQUIRE;
		else
			state_ff <= nxt_state;
	end

	// Internal conversion timer
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			count_ff <= adc_port_pkg::CNT_RESET;
		else if (start_conv)
			count_ff <= adc_port_pkg::CNT_LOAD;
		else if (count_ff != adc_port_pkg::CNT_RESET)
			count_ff <= count_ff - 1'b1;
	end

	// Busy flag
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			busy_ff <= 1'b0;
		else if (start_conv)
			busy_ff <= 1'b1;
		else if (abort_conv)
			busy_ff <= 1'b0;
		else if (end_conv)
			busy_ff <= 1'b0;
	end

	// Track phase
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			sampling_ff <= 1'b0;
		else if (start_conv)
			sampling_ff <= 1'b0;
		else if (abort_conv)
			sampling_ff <= 1'b1;
		else if (end_conv && cs_low)
			sampling_ff <= 1'b1;
		else if ((state_ff == adc_port_pkg::ST_ACQUIRE) && cs_fall)
			sampling_ff <= 1'b1;
	end

	// Self reset pulse
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			self_reset_ff <= 1'b0;
		else
			self_reset_ff <= abort_conv;
	end

	// Output latch
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			latch_ff <= adc_port_pkg::LATCH_RESET;
		else if (abort_conv)
			latch_ff <= adc_port_pkg::LATCH_RESET;
		else if (end_conv)
			latch_ff <= fifo_data;
	end

	// Bus enable
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			oe_ff <= 1'b0;
		else
			oe_ff <= cs_low && rd_low;
	end

	// Bus data and byte steering
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			bus_ff <= adc_port_pkg::BUS_IDLE;
		else if (byte_high)
			bus_ff <= {latch_ff[7:0], adc_port_pkg::FILL_ONES};
		else
			bus_ff <= latch_ff;
	end

	assign result_bus_pins = bus_ff;
	assign result_bus_oe = oe_ff;
	assign busy = busy_ff;
	assign sampling = sampling_ff;
	assign self_reset = self_reset_ff;

	// Cycles spent busy, for the timing check
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			conv_age_ff <= adc_port_pkg::CNT_RESET;
		else if (start_conv)
			conv_age_ff <= adc_port_pkg::CNT_RESET;
		else if (busy_ff && (conv_age_ff != adc_port_pkg::CNT_LOAD))
			conv_age_ff <= conv_age_ff + 1'b1;
	end

	// Checks
	busy_rise_a: assert property (@(posedge clock) disable iff (!reset_n)
		start_conv |=> busy_ff && (state_ff == adc_port_pkg::ST_CONVERT))
		else $error("busy did not rise after convert start");

	busy_conv_a: assert property (@(posedge clock) disable iff (!reset_n)
		busy_ff == (state_ff == adc_port_pkg::ST_CONVERT))
		else $error("busy disagrees with conversion state");

	conv_time_a: assert property (@(posedge clock) disable iff (!reset_n)
		end_conv |-> conv_age_ff == adc_port_pkg::CNT_LOAD)
		else $error("conversion ended before its internal time");

	sample_start_a: assert property (@(posedge clock) disable iff (!reset_n)
		end_conv && cs_low |=> !busy_ff && sampling_ff)
		else $error("sampling did not start at busy fall");

	cs_sample_a: assert property (@(posedge clock) disable iff (!reset_n)
		(state_ff == adc_port_pkg::ST_ACQUIRE) && cs_fall && !start_conv |=> sampling_ff)
		else $error("sampling did not start at select fall");

	bus_drive_a: assert property (@(posedge clock) disable iff (!reset_n)
		##1 result_bus_oe |-> $past(cs_low) && $past(rd_low))
		else $error("bus driven without select and read");

	word_out_a: assert property (@(posedge clock) disable iff (!reset_n)
		!byte_high ##1 result_bus_oe |-> result_bus_pins == $past(latch_ff))
		else $error("word read shows wrong data");

	byte_out_a: assert property (@(posedge clock) disable iff (!reset_n)
		byte_high ##1 result_bus_oe |-> result_bus_pins[15:8] == $past(latch_ff[7:0])
		&& result_bus_pins[7:0] == adc_port_pkg::FILL_ONES)
		else $error("byte read shows wrong data");

	reset_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
		abort_conv |=> self_reset_ff && !busy_ff && latch_ff == adc_port_pkg::LATCH_RESET)
		else $error("self reset did not clear latch and busy");

	cs_reset_a: assert property (@(posedge clock) disable iff (!reset_n)
		(state_ff == adc_port_pkg::ST_CONVERT) && cs_fall |=> self_reset_ff)
		else $error("select fall in conversion did not reset");

	reset_sample_a: assert property (@(posedge clock) disable iff (!reset_n)
		self_reset_ff |-> sampling_ff && $fell(busy_ff))
		else $error("no sampling after self reset");

	latch_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
		!$past(end_conv) && !$past(abort_conv) |-> $stable(latch_ff))
		else $error("latch changed without conversion end");

	bus_float_a: assert property (@(posedge clock) disable iff (!reset_n)
		!(cs_low && rd_low) |=> !result_bus_oe)
		else $error("bus driven without select and read");

	latch_load_a: assert property (@(posedge clock) disable iff (!reset_n)
		end_conv |=> latch_ff == $past(fifo_data))
		else $error("latch did not take the new result");
endmodule // adc_parallel_readout_reset

/* File: verification/host_model.sv */
`timescale 1ns/1ps
module host_model (
	input wire logic clock,
	output logic chip_select_n,
	output logic read_n,
	output logic convert_start_n,
	output logic byte_select
);
	initial
	begin
		chip_select_n = 1'b1;
		read_n = 1'b1;
		convert_start_n = 1'b1;
		byte_select = 1'b0;
	end

	// Bus pins move together, then stay quiet
	task automatic pins(input logic cs, input logic rd, input logic bs);
		@(negedge clock);
		chip_select_n = cs;
		read_n = rd;
		byte_select = bs;
		repeat (6) @(negedge clock);
	endtask

	task automatic conv(input logic v);
		@(negedge clock);
		convert_start_n = v;
	endtask

	task automatic sel(input logic v);
		@(negedge clock);
		chip_select_n = v;
	endtask
endmodule // host_model

/* File: verification/adc_parallel_readout_reset_tb.sv */
`timescale 1ns/1ps
module adc_parallel_readout_reset_tb;
	logic clock;
	logic reset_n;
	logic [15:0] code_data;
	logic code_valid;
	logic code_ready;
	logic [15:0] result_bus_pins;
	logic result_bus_oe;
	logic busy;
	logic sampling;
	logic self_reset;
	logic chip_select_n;
	logic read_n;
	logic convert_start_n;
	logic byte_select;
	int n_errors = 0;
	int comparisons = 0;

	always #50 clock = ~clock;

	host_model host (
		.clock(clock),
		.chip_select_n(chip_select_n),
		.read_n(read_n),
		.convert_start_n(convert_start_n),
		.byte_select(byte_select)
	);

	adc_parallel_readout_reset u_adc_parallel_readout_reset (
		.clock(clock),
		.reset_n(reset_n),
		.chip_select_n(chip_select_n),
		.read_n(read_n),
		.convert_start_n(convert_start_n),
		.byte_select(byte_select),
		.code_data(code_data),
		.code_valid(code_valid),
		.code_ready(code_ready),
		.result_bus_pins(result_bus_pins),
		.result_bus_oe(result_bus_oe),
		.busy(busy),
		.sampling(sampling),
		.self_reset(self_reset)
	);

	task automatic print_verdict();
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk_bus(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_flag(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic read16(input logic [15:0] exp);
		host.pins(1'b0, 1'b0, 1'b0);
		chk_flag("oe", 1'b1, result_bus_oe);
		chk_bus("bus", exp, result_bus_pins);
		host.pins(1'b0, 1'b1, 1'b0);
		chk_flag("oe", 1'b0, result_bus_oe);
	endtask

	task automatic start_conv();
		int n;
		host.conv(1'b0);
		for (n = 0; n < 8 && busy !== 1'b1; n++)
			@(negedge clock);
		chk_flag("busy", 1'b1, busy);
		chk_flag("sampling", 1'b0, sampling);
		host.conv(1'b1);
	endtask

	task automatic conv_read(input logic [15:0] exp);
		int n;
		start_conv();
		repeat (8) @(negedge clock);
		chk_flag("busy", 1'b1, busy);
		for (n = 0; n < 8 && busy !== 1'b0; n++)
			@(negedge clock);
		chk_flag("busy", 1'b0, busy);
		chk_flag("sampling", 1'b1, sampling);
		read16(exp);
	endtask

	task automatic push(input logic [15:0] d);
		@(negedge clock);
		code_data = d;
		code_valid = 1'b1;
		@(negedge clock);
		code_valid = 1'b0;
	endtask

	task automatic t_reset();
		@(negedge clock);
		chk_flag("code_ready", 1'b1, code_ready);
		chk_flag("busy", 1'b0, busy);
		chk_flag("oe", 1'b0, result_bus_oe);
		chk_flag("self_reset", 1'b0, self_reset);
		chk_bus("bus", 16'h0000, result_bus_pins);
	endtask

	task automatic t_refused();
		host.pins(1'b1, 1'b1, 1'b0);
		host.conv(1'b0);
		repeat (8) @(negedge clock);
		chk_flag("busy", 1'b0, busy);
		host.conv(1'b1);
		host.pins(1'b0, 1'b1, 1'b0);
		chk_flag("sampling", 1'b1, sampling);
	endtask

	task automatic t_codes();
		push(16'h0000);
		push(16'h8000);
		push(16'h7FFF);
		push(16'hFFFF);
		conv_read(16'h0000);
		conv_read(16'h8000);
		conv_read(16'h7FFF);
		conv_read(16'hFFFF);
	endtask

	task automatic t_byte();
		push(16'hA55A);
		conv_read(16'hA55A);
		host.pins(1'b0, 1'b0, 1'b0);
		chk_bus("high byte", 16'h00A5, {8'h00, result_bus_pins[15:8]});
		host.pins(1'b0, 1'b0, 1'b1);
		chk_bus("low byte", 16'h5AFF, result_bus_pins);
		host.pins(1'b0, 1'b1, 1'b0);
		host.pins(1'b0, 1'b0, 1'b1);
		chk_bus("low byte", 16'h5AFF, result_bus_pins);
		host.pins(1'b1, 1'b0, 1'b1);
		chk_flag("oe", 1'b0, result_bus_oe);
		host.pins(1'b0, 1'b1, 1'b0);
		read16(16'hA55A);
	endtask

	task automatic t_abort(input logic by_cs);
		int n;
		start_conv();
		repeat (20) @(negedge clock);
		chk_flag("busy", 1'b1, busy);
		if (by_cs)
		begin
			host.pins(1'b1, 1'b1, 1'b0);
			host.sel(1'b0);
		end
		else
			host.conv(1'b0);
		for (n = 0; n < 8 && self_reset !== 1'b1; n++)
			@(negedge clock);
		chk_flag("self_reset", 1'b1, self_reset);
		chk_flag("busy", 1'b0, busy);
		chk_flag("sampling", 1'b1, sampling);
		host.conv(1'b1);
		read16(16'h0000);
	endtask

	task automatic t_fill();
		int i;
		for (i = 0; i < 16; i++)
		begin
			@(negedge clock);
			code_data = 16'h0F00 + 16'(i);
			code_valid = 1'b1;
		end
		@(negedge clock);
		code_valid = 1'b0;
		@(negedge clock);
		chk_flag("code_ready", 1'b0, code_ready);
		push(16'hDEAD);
		for (i = 0; i < 16; i++)
			conv_read(16'h0F00 + 16'(i));
		t_abort(1'b1);
	endtask

	initial
	begin
		repeat (20000) @(posedge clock);
		n_errors++;
		print_verdict();
	end

	initial
	begin
		clock = 1'b0;
		reset_n = 1'b0;
		code_data = 16'h0000;
		code_valid = 1'b0;
		repeat (6) @(negedge clock);
		reset_n = 1'b1;
		t_reset();
		t_refused();
		t_codes();
		t_byte();
		t_abort(1'b0);
		t_fill();
		print_verdict();
	end
endmodule // adc_parallel_readout_reset_tb
